//--- rtl/bcnt_pkg.sv
package bcnt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Counter geometry and values
  localparam int CNT_W = 8;                       // Counter state width
  localparam logic [7:0] CNT_RST = 8'h00;         // Count after reset
  localparam logic [7:0] CNT_ONES = 8'hff;        // Terminal value counting up
  localparam logic [7:0] CNT_ZERO = 8'h00;        // Terminal value counting down
  localparam logic [7:0] CNT_ONE = 8'h01;         // Count step
  localparam int WRAP_W = 16;                     // Wrap event counter width
  localparam logic [15:0] WRAP_RST = 16'h0000;    // Wrap count after reset
  localparam logic [15:0] WRAP_ONE = 16'h0001;    // Wrap count step

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam int ADDR_W = 12;                     // Decoded address width
  localparam logic [11:0] CTRL_OFS = 12'h000;     // Control register
  localparam logic [11:0] STAT_OFS = 12'h004;     // Status register
  localparam logic [11:0] WRAP_OFS = 12'h008;     // Wrap event count
  localparam int CTRL_EN_BIT = 0;                 // Wrap counting enable
  localparam int CTRL_CLR_BIT = 1;                // Wrap count clear, write one
  localparam logic CTRL_EN_RST = 1'b0;            // Enable after reset
  localparam int STAT_CNT_LSB = 0;                // Count field
  localparam int STAT_TC_BIT = 8;                 // Terminal count level
  localparam int STAT_OE_BIT = 9;                 // Bus driven flag
  localparam int STAT_MODE_LSB = 10;              // Mode select field, 2 bits
  localparam logic [31:0] RDATA_RST = 32'h0000_0000; // Read data after reset

  ////////////////////////////////////////////////////////////////////////////
  // Operations chosen by the two mode selects {hi, lo}
  typedef enum logic [1:0] {
    BCNT_LOAD = 2'b00,
    BCNT_DOWN = 2'b01,
    BCNT_UP   = 2'b10,
    BCNT_HOLD = 2'b11
  } bcnt_mode_t;

  // Decode of the select pins, shared by datapath and checks
  function automatic bcnt_mode_t bcnt_mode_of(input logic sel_hi, input logic sel_lo);
    return bcnt_mode_t'({sel_hi, sel_lo});
  endfunction : bcnt_mode_of

endpackage : bcnt_pkg

//--- rtl/bcnt_step.sv
`timescale 1ns/10ps
module bcnt_step #(
  parameter int CNT_W = bcnt_pkg::CNT_W         // Counter width
) (
  input wire logic [CNT_W-1:0] count_in,        // Present count
  input wire logic [CNT_W-1:0] load_data_in,    // Data sampled from the bus
  input wire logic mode_select_hi_in,           // Mode select high bit
  input wire logic mode_select_lo_in,           // Mode select low bit
  input wire logic count_enable_n_in,           // Count enable, active low
  output logic [CNT_W-1:0] nxt_count_out,       // Value for the next edge
  output logic terminal_count_n_out             // Look-ahead carry, active low
);

  bcnt_pkg::bcnt_mode_t mode; // Decoded operation

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the counter
  always_comb begin
    mode = bcnt_pkg::bcnt_mode_of(mode_select_hi_in, mode_select_lo_in);
    nxt_count_out = count_in; // Hold by default
    unique case (mode)
      bcnt_pkg::BCNT_LOAD: begin
        nxt_count_out = load_data_in; // Load ignores count enable
      end
      bcnt_pkg::BCNT_UP: begin
        if (!count_enable_n_in) begin
          nxt_count_out = CNT_W'(count_in + bcnt_pkg::CNT_ONE); // Wraps
        end
      end
      bcnt_pkg::BCNT_DOWN: begin
        if (!count_enable_n_in) begin
          nxt_count_out = CNT_W'(count_in - bcnt_pkg::CNT_ONE); // Wraps
        end
      end
      bcnt_pkg::BCNT_HOLD: begin
        nxt_count_out = count_in; // Both selects high keeps the value
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Terminal count, gated straight by the count enable
  always_comb begin
    terminal_count_n_out = 1'b1; // High whenever no carry is due
    if (!count_enable_n_in) begin
      if ((mode == bcnt_pkg::BCNT_UP) && (count_in == bcnt_pkg::CNT_ONES)) begin
        terminal_count_n_out = 1'b0; // Top of an up count
      end else if ((mode == bcnt_pkg::BCNT_DOWN) && (count_in == bcnt_pkg::CNT_ZERO)) begin
        terminal_count_n_out = 1'b0; // Bottom of a down count
      end
    end
  end

endmodule : bcnt_step

//--- rtl/bcnt_apb.sv
`timescale 1ns/10ps
module bcnt_apb #(
  parameter int ADDR_W = bcnt_pkg::ADDR_W,      // Decoded address width
  parameter int WRAP_W = bcnt_pkg::WRAP_W       // Wrap counter width
) (
  input wire logic core_clk_in,                 // Core clock
  input wire logic resetn_in,                   // Synchronous reset, active low
  input wire logic apb_psel_in,                 // APB select
  input wire logic apb_penable_in,              // APB access phase
  input wire logic apb_pwrite_in,               // APB direction, high writes
  input wire logic [ADDR_W-1:0] apb_paddr_in,   // APB byte address
  input wire logic [31:0] apb_pwdata_in,        // APB write data
  input wire logic [31:0] stat_in,              // Status word from the core
  input wire logic [WRAP_W-1:0] wrap_in,        // Wrap event count
  output logic [31:0] apb_prdata_out,           // APB read data, registered
  output logic apb_pready_out,                  // APB ready, no wait states
  output logic apb_pslverr_out,                 // APB error on unmapped address
  output logic ctrl_en_out,                     // Wrap counting enable
  output logic wrap_clr_out                     // Wrap clear pulse
);

  logic ctrl_en_ff;     // Enable bit of the control register
  logic [31:0] rdata_ff; // Read data captured in the setup phase
  logic hit;            // Address maps to a register
  logic wr_take;        // Write taken at this edge

  // Address decode and taken write
  assign hit = (apb_paddr_in == bcnt_pkg::CTRL_OFS) || (apb_paddr_in == bcnt_pkg::STAT_OFS)
    || (apb_paddr_in == bcnt_pkg::WRAP_OFS);
  assign wr_take = apb_psel_in && apb_penable_in && apb_pwrite_in && hit;
  assign apb_pready_out = 1'b1;
  assign apb_pslverr_out = apb_psel_in && apb_penable_in && !hit;
  assign apb_prdata_out = rdata_ff;
  assign ctrl_en_out = ctrl_en_ff;
  assign wrap_clr_out = wr_take && (apb_paddr_in == bcnt_pkg::CTRL_OFS)
    && apb_pwdata_in[bcnt_pkg::CTRL_CLR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ctrl_en_ff <= bcnt_pkg::CTRL_EN_RST;
    end else if (wr_take && (apb_paddr_in == bcnt_pkg::CTRL_OFS)) begin
      ctrl_en_ff <= apb_pwdata_in[bcnt_pkg::CTRL_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, latched during the setup phase
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      rdata_ff <= bcnt_pkg::RDATA_RST;
    end else if (apb_psel_in && !apb_penable_in && !apb_pwrite_in) begin
      unique case (apb_paddr_in)
        bcnt_pkg::CTRL_OFS: rdata_ff <= {31'h0000_0000, ctrl_en_ff};
        bcnt_pkg::STAT_OFS: rdata_ff <= stat_in;
        bcnt_pkg::WRAP_OFS: rdata_ff <= 32'(wrap_in);
        default: rdata_ff <= bcnt_pkg::RDATA_RST; // Unmapped reads zero
      endcase
    end
  end

endmodule : bcnt_apb

//--- rtl/bcnt_core.sv
// The address map and the APB register port were left to the implementer.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module bcnt_core #(
  parameter int CNT_W = bcnt_pkg::CNT_W,        // Counter width
  parameter int WRAP_W = bcnt_pkg::WRAP_W,      // Wrap event counter width
  parameter int ADDR_W = bcnt_pkg::ADDR_W       // APB address width
) (
  input wire logic core_clk_in,                 // Core clock, 250 MHz
  input wire logic resetn_in,                   // Synchronous reset, active low
  input wire logic mode_select_hi_in,           // Mode select high bit
  input wire logic mode_select_lo_in,           // Mode select low bit
  input wire logic count_enable_n_in,           // Count enable, active low
  input wire logic output_enable_n_in,          // Bus drive enable, active low
  input wire logic [CNT_W-1:0] io_data_in,      // Shared data lines, sensed
  output logic [CNT_W-1:0] io_data_out,         // Shared data lines, driven value
  output logic [CNT_W-1:0] io_data_oe_out,      // Drive enable per line, high drives
  output logic terminal_count_n_out,            // Look-ahead carry, active low
  input wire logic apb_psel_in,                 // APB select
  input wire logic apb_penable_in,              // APB access phase
  input wire logic apb_pwrite_in,               // APB direction
  input wire logic [ADDR_W-1:0] apb_paddr_in,   // APB byte address
  input wire logic [31:0] apb_pwdata_in,        // APB write data
  output logic [31:0] apb_prdata_out,           // APB read data
  output logic apb_pready_out,                  // APB ready
  output logic apb_pslverr_out                  // APB slave error
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [CNT_W-1:0] count_ff;      // Counter state
  logic [CNT_W-1:0] nxt_count;     // Counter next state
  logic [WRAP_W-1:0] wrap_ff;      // Count of carries out
  logic [WRAP_W-1:0] nxt_wrap;     // Next wrap count
  logic tc_n;                      // Terminal count from the datapath
  logic wrap_en;                   // Wrap counting enabled by software
  logic wrap_clr;                  // Wrap clear pulse from software
  logic carry_evt;                 // Counter wraps at this edge
  logic [31:0] stat_word;          // Status word for software
  bcnt_pkg::bcnt_mode_t mode;      // Decoded operation

  // Operation currently selected on the pins
  assign mode = bcnt_pkg::bcnt_mode_of(mode_select_hi_in, mode_select_lo_in);

  //////////////////////////////////////////////////////////////////////////////
  // Next-state datapath
  bcnt_step #(
    .CNT_W(CNT_W)
  ) u_step (
    .count_in(count_ff),
    .load_data_in(io_data_in),
    .mode_select_hi_in(mode_select_hi_in),
    .mode_select_lo_in(mode_select_lo_in),
    .count_enable_n_in(count_enable_n_in),
    .nxt_count_out(nxt_count),
    .terminal_count_n_out(tc_n)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Counter state, updated on the rising edge only
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      count_ff <= bcnt_pkg::CNT_RST;
    end else begin
      count_ff <= nxt_count; // Load, count or hold
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared data lines
  // Drive value always comes from the flip-flops
  assign io_data_out = count_ff;
  // All lines float together when the enable is high
  assign io_data_oe_out = {CNT_W{!output_enable_n_in}};

  // Carry is combinational so cascaded stages see it within the cycle;
  // it may glitch, so the partner samples it only as a level
  assign terminal_count_n_out = tc_n;

  //////////////////////////////////////////////////////////////////////////////
  // Wrap event counter
  // A carry out is due when the terminal count is low
  assign carry_evt = !tc_n;

  // Clear and event in the same cycle keep the event
  always_comb begin
    nxt_wrap = wrap_ff;
    if (wrap_clr) begin
      nxt_wrap = (wrap_en && carry_evt) ? bcnt_pkg::WRAP_ONE : bcnt_pkg::WRAP_RST;
    end else if (wrap_en && carry_evt) begin
      nxt_wrap = WRAP_W'(wrap_ff + bcnt_pkg::WRAP_ONE);
    end
  end

  // Wrap count register
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      wrap_ff <= bcnt_pkg::WRAP_RST;
    end else begin
      wrap_ff <= nxt_wrap;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status word
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[bcnt_pkg::STAT_CNT_LSB +: CNT_W] = count_ff;
    stat_word[bcnt_pkg::STAT_TC_BIT] = tc_n;
    stat_word[bcnt_pkg::STAT_OE_BIT] = !output_enable_n_in;
    stat_word[bcnt_pkg::STAT_MODE_LSB +: 2] = mode;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register bus slave
  bcnt_apb #(
    .ADDR_W(ADDR_W),
    .WRAP_W(WRAP_W)
  ) u_apb (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .apb_psel_in(apb_psel_in),
    .apb_penable_in(apb_penable_in),
    .apb_pwrite_in(apb_pwrite_in),
    .apb_paddr_in(apb_paddr_in),
    .apb_pwdata_in(apb_pwdata_in),
    .stat_in(stat_word),
    .wrap_in(wrap_ff),
    .apb_prdata_out(apb_prdata_out),
    .apb_pready_out(apb_pready_out),
    .apb_pslverr_out(apb_pslverr_out),
    .ctrl_en_out(wrap_en),
    .wrap_clr_out(wrap_clr)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // Load takes the bus value whatever the enable
  a_load_takes_bus: assert property (
    (mode == bcnt_pkg::BCNT_LOAD) |=> (count_ff == $past(io_data_in)))
    else $error("load did not take bus value");

  // Up step by one
  a_up_step_one: assert property (
    (mode == bcnt_pkg::BCNT_UP) && !count_enable_n_in
    |=> (count_ff == CNT_W'($past(count_ff) + bcnt_pkg::CNT_ONE)))
    else $error("count up step wrong");

  // Down step by one
  a_down_step_one: assert property (
    (mode == bcnt_pkg::BCNT_DOWN) && !count_enable_n_in
    |=> (count_ff == CNT_W'($past(count_ff) - bcnt_pkg::CNT_ONE)))
    else $error("count down step wrong");

  // Enable high holds the count in every mode but load
  a_hold_keeps_count: assert property (
    count_enable_n_in && (mode != bcnt_pkg::BCNT_LOAD) |=> $stable(count_ff))
    else $error("count moved while held");

  // Enable high forces terminal count high
  a_hold_tc_high: assert property (
    count_enable_n_in |-> terminal_count_n_out)
    else $error("terminal count low while disabled");

  // Enable low alone lets up/down move the count
  a_enable_low_moves: assert property (
    !count_enable_n_in && mode[1] != mode[0] |=> (count_ff != $past(count_ff)))
    else $error("count did not move while enabled");

  // Driving when output enable low
  a_bus_driven: assert property (
    !output_enable_n_in |-> (io_data_oe_out == {CNT_W{1'b1}}) && (io_data_out == count_ff))
    else $error("bus not driven with count");

  // Floating when output enable high
  a_bus_floats: assert property (
    output_enable_n_in |-> (io_data_oe_out == {CNT_W{1'b0}}))
    else $error("bus driven while disabled");

  // Terminal low exactly at the top or bottom of a count
  a_tc_decode: assert property (
    !terminal_count_n_out == (!count_enable_n_in
      && (((mode == bcnt_pkg::BCNT_UP) && (count_ff == bcnt_pkg::CNT_ONES))
      || ((mode == bcnt_pkg::BCNT_DOWN) && (count_ff == bcnt_pkg::CNT_ZERO)))))
    else $error("terminal count decode wrong");

  // Terminal low while counting up means the next value is zero
  a_wrap_up_zero: assert property (
    !terminal_count_n_out && (mode == bcnt_pkg::BCNT_UP) |=> (count_ff == bcnt_pkg::CNT_ZERO))
    else $error("up count did not wrap to zero");

  // Terminal low while counting down means the next value is all ones
  a_wrap_down_ones: assert property (
    !terminal_count_n_out && (mode == bcnt_pkg::BCNT_DOWN) |=> (count_ff == bcnt_pkg::CNT_ONES))
    else $error("down count did not wrap to ones");

  // Four steady up edges add four to the count
  a_run_adds_four: assert property (
    ((mode == bcnt_pkg::BCNT_UP) && !count_enable_n_in)[*4]
    |=> (count_ff == CNT_W'($past(count_ff, 4) + CNT_W'(4))))
    else $error("four up steps did not add four");

  // Carry while enabled bumps the wrap count
  a_wrap_event_count: assert property (
    wrap_en && carry_evt && !wrap_clr |=> (wrap_ff == WRAP_W'($past(wrap_ff) + bcnt_pkg::WRAP_ONE)))
    else $error("wrap event not counted");

  // Clear with a coincident carry keeps the carry
  a_clear_keeps_event: assert property (
    wrap_clr && wrap_en && carry_evt |=> (wrap_ff == bcnt_pkg::WRAP_ONE))
    else $error("wrap event lost on clear");

endmodule : bcnt_core

//--- rtl/README_unused.sv
`timescale 1ns/10ps

//--- testbench/bcnt_partner.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Bus master on the shared data lines, with line resolution
module bcnt_partner (
  input wire logic clk_in,                      // Core clock
  input wire logic drive_en_in,                 // Master wants the lines
  input wire logic [7:0] drive_data_in,         // Value the master puts out
  input wire logic [7:0] dev_data_in,           // Value the counter drives
  input wire logic [7:0] dev_oe_in,             // Counter drive enables
  output logic [7:0] bus_out,                   // Resolved line level
  output logic clash_out                        // Both parties drive at once
);

  logic [7:0] last_ff = 8'h00;                  // Last resolved level

  ////////////////////////////////////////////////////////////////////////////
  // Resolve lines; floating lines show the inverse of the last level
  always_comb begin
    bus_out = (dev_oe_in & dev_data_in) |
              (~dev_oe_in & (drive_en_in ? drive_data_in : ~last_ff));
    clash_out = drive_en_in & (|dev_oe_in);     // Set when the master drives while any device line drives
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remember level so a released line never keeps a stale value
  always @(posedge clk_in) begin
    last_ff <= bus_out;
  end

endmodule : bcnt_partner

//--- testbench/tb.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Testbench top: pin steps and APB transfers with expected values
module tb;

  logic core_clk_in, resetn_in;                 // Clock and reset
  logic sel_hi, sel_lo, cnt_en_n, out_en_n;     // Pin controls
  logic [7:0] io_in, io_out, io_oe;             // Shared line signals
  logic tc_n;                                   // Terminal count
  logic drv_en, clash, clash_ff;                // Master drive and contention
  logic [7:0] drv_data;                         // Master drive value
  logic psel, penable, pwrite, pready, pslverr; // APB controls
  logic [11:0] paddr;                           // APB address
  logic [31:0] pwdata, prdata, rd;              // APB data
  logic err;                                    // Captured slave error
  int errors, n_checks;                         // Report counters

  bcnt_core uut (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .mode_select_hi_in(sel_hi), .mode_select_lo_in(sel_lo),
    .count_enable_n_in(cnt_en_n), .output_enable_n_in(out_en_n),
    .io_data_in(io_in), .io_data_out(io_out), .io_data_oe_out(io_oe),
    .terminal_count_n_out(tc_n), .apb_psel_in(psel), .apb_penable_in(penable),
    .apb_pwrite_in(pwrite), .apb_paddr_in(paddr), .apb_pwdata_in(pwdata),
    .apb_prdata_out(prdata), .apb_pready_out(pready), .apb_pslverr_out(pslverr));

  bcnt_partner master (.clk_in(core_clk_in), .drive_en_in(drv_en),
    .drive_data_in(drv_data), .dev_data_in(io_out), .dev_oe_in(io_oe),
    .bus_out(io_in), .clash_out(clash));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and sticky contention flag
  always #2 core_clk_in = ~core_clk_in;

  always @(posedge core_clk_in) begin
    if (clash) clash_ff <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, comparisons and drivers
  task automatic give_verdict();
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  // One pin step: inputs change after an edge, outputs settle 1 ns later
  task automatic pins(input logic [1:0] m, input logic en_n, input logic oe_n,
                      input logic drv, input logic [7:0] d);
    @(posedge core_clk_in);
    sel_hi <= m[1];
    sel_lo <= m[0];
    cnt_en_n <= en_n;
    out_en_n <= oe_n;
    drv_en <= drv;
    drv_data <= d;
    #1;
  endtask : pins

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk_in);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge core_clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    core_clk_in = 1'b0;
    resetn_in = 1'b0;
    {sel_hi, sel_lo, cnt_en_n, out_en_n} = 4'hf;
    {drv_en, clash_ff, psel, penable, pwrite} = 5'h00;
    drv_data = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    errors = 0;
    n_checks = 0;
    repeat (20) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    pins(bcnt_pkg::BCNT_HOLD, 1'b1, 1'b0, 1'b0, 8'h00);
    chk_pin(io_out, bcnt_pkg::CNT_RST);
    chk_pin(io_oe, 8'hff);
    pins(bcnt_pkg::BCNT_LOAD, 1'b1, 1'b1, 1'b1, 8'h5a);
    chk_pin(io_oe, 8'h00);
    pins(bcnt_pkg::BCNT_HOLD, 1'b0, 1'b0, 1'b0, 8'h00);
    chk_pin(io_out, 8'h5a);
    chk_pin({7'h00, tc_n}, 8'h01);
    pins(bcnt_pkg::BCNT_UP, 1'b1, 1'b0, 1'b0, 8'h00);
    chk_pin(io_out, 8'h5a);
    pins(bcnt_pkg::BCNT_UP, 1'b0, 1'b0, 1'b0, 8'h00);
    chk_pin(io_out, 8'h5a);
    pins(bcnt_pkg::BCNT_DOWN, 1'b0, 1'b0, 1'b0, 8'h00);
    chk_pin(io_out, 8'h5b);
    pins(bcnt_pkg::BCNT_HOLD, 1'b1, 1'b0, 1'b0, 8'h00);
    chk_pin(io_out, 8'h5a);
    apb(1'b1, bcnt_pkg::CTRL_OFS, 32'h0000_0001);
    // Load with enable low: enable must be ignored
    pins(bcnt_pkg::BCNT_LOAD, 1'b0, 1'b1, 1'b1, 8'hff);
    pins(bcnt_pkg::BCNT_UP, 1'b0, 1'b0, 1'b0, 8'h00);
    chk_pin(io_out, bcnt_pkg::CNT_ONES);
    chk_pin({7'h00, tc_n}, 8'h00);
    pins(bcnt_pkg::BCNT_UP, 1'b1, 1'b0, 1'b0, 8'h00);
    chk_pin(io_out, bcnt_pkg::CNT_ZERO);
    chk_pin({7'h00, tc_n}, 8'h01);
    pins(bcnt_pkg::BCNT_DOWN, 1'b0, 1'b0, 1'b0, 8'h00);
    chk_pin(io_out, bcnt_pkg::CNT_ZERO);
    chk_pin({7'h00, tc_n}, 8'h00);
    // Hold with selects high only, never both low
    pins(bcnt_pkg::BCNT_HOLD, 1'b1, 1'b0, 1'b0, 8'h00);
    chk_pin(io_out, bcnt_pkg::CNT_ONES);
    chk_pin({7'h00, tc_n}, 8'h01);
    // Registers: status, wrap events, clear, unmapped place
    apb(1'b0, bcnt_pkg::STAT_OFS, 32'h0);
    chk_reg(rd, (32'h3 << bcnt_pkg::STAT_MODE_LSB) | (32'h1 << bcnt_pkg::STAT_OE_BIT) |
            (32'h1 << bcnt_pkg::STAT_TC_BIT) | 32'(bcnt_pkg::CNT_ONES));
    apb(1'b0, bcnt_pkg::WRAP_OFS, 32'h0);
    chk_reg(rd, 32'h0000_0002);
    apb(1'b1, bcnt_pkg::CTRL_OFS, 32'h0000_0003);
    apb(1'b0, bcnt_pkg::WRAP_OFS, 32'h0);
    chk_reg(rd, 32'h0000_0000);
    apb(1'b0, bcnt_pkg::CTRL_OFS, 32'h0);
    chk_reg(rd, 32'h0000_0001);
    apb(1'b0, 12'h00c, 32'h0);
    chk_reg(rd, 32'h0000_0000);
    chk_pin({7'h00, err}, 8'h01);
    // Mid-run reset, then a long up run across the top of the count
    @(posedge core_clk_in);
    resetn_in <= 1'b0;
    @(posedge core_clk_in);
    resetn_in <= 1'b1;
    pins(bcnt_pkg::BCNT_LOAD, 1'b1, 1'b1, 1'b1, 8'hfd);
    chk_pin(io_out, bcnt_pkg::CNT_RST);
    pins(bcnt_pkg::BCNT_UP, 1'b0, 1'b0, 1'b0, 8'h00);
    chk_pin(io_out, 8'hfd);
    repeat (4) pins(bcnt_pkg::BCNT_UP, 1'b0, 1'b0, 1'b0, 8'h00);
    chk_pin(io_out, 8'h01);
    pins(bcnt_pkg::BCNT_HOLD, 1'b1, 1'b0, 1'b0, 8'h00);
    chk_pin(io_out, 8'h02);
    // Enable cleared by reset, so the carry above is not counted
    apb(1'b0, bcnt_pkg::CTRL_OFS, 32'h0);
    chk_reg(rd, 32'h0000_0000);
    apb(1'b0, bcnt_pkg::WRAP_OFS, 32'h0);
    chk_reg(rd, 32'h0000_0000);
    // Master and counter never drove the lines at the same time
    chk_pin({7'h00, clash_ff}, 8'h00);
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs well under 200 cycles
  initial begin
    #20000;
    errors++;
    give_verdict();
  end

endmodule : tb
